// ---- core/ckms_pkg.sv ----
package ckms_pkg;

  // ----------------------------------------------------------------------
  // Register map (indices; byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [9:0] CKMS_IDX_CLOCK_SOURCE_SELECT = 10'h0A9;
  localparam logic [9:0] CKMS_IDX_MULTIPLIER_CONTROL  = 10'h0B9;
  localparam logic [9:0] CKMS_IDX_OSC_STATUS          = 10'h0BA;

  localparam logic [7:0] CKMS_CLOCK_SOURCE_SELECT_RESET = 8'h00;
  localparam logic [7:0] CKMS_MULCTL_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CKMS_MUL_EN_BIT   = 7;
  localparam int CKMS_MUL_INIT_BIT = 6;
  localparam int CKMS_MUL_LOCK_BIT = 5;
  localparam int CKMS_MUL_SRC_LSB  = 0;
  localparam int CKMS_USB_SEL_LSB  = 4;
  localparam int CKMS_SYS_SEL_LSB  = 0;
  localparam int CKMS_XTAL_VLD_BIT = 0;

  // ----------------------------------------------------------------------
  // Source codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] CKMS_MSRC_INT   = 2'h0;
  localparam logic [1:0] CKMS_MSRC_EXT   = 2'h1;
  localparam logic [1:0] CKMS_MSRC_EXT2  = 2'h2;

  localparam logic [2:0] CKMS_SYS_INT    = 3'h0;
  localparam logic [2:0] CKMS_SYS_EXT    = 3'h1;
  localparam logic [2:0] CKMS_SYS_MUL2   = 3'h2;
  localparam logic [2:0] CKMS_SYS_MUL    = 3'h3;
  localparam logic [2:0] CKMS_SYS_LFO    = 3'h4;

  localparam logic [2:0] CKMS_USB_MUL    = 3'h0;
  localparam logic [2:0] CKMS_USB_INT2   = 3'h1;
  localparam logic [2:0] CKMS_USB_EXT    = 3'h2;
  localparam logic [2:0] CKMS_USB_EXT2   = 3'h3;
  localparam logic [2:0] CKMS_USB_EXT3   = 3'h4;
  localparam logic [2:0] CKMS_USB_EXT4   = 3'h5;

  // ----------------------------------------------------------------------
  // Timing counts and bus answers
  // ----------------------------------------------------------------------
  localparam int         CKMS_MUL_FACTOR   = 4;
  localparam int         CKMS_XTAL_EDGES   = 1024;
  localparam int         CKMS_MIN_PERIOD   = 8;
  localparam logic [1:0] CKMS_RESP_OKAY    = 2'h0;
  localparam logic [1:0] CKMS_RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    CKMS_MUL_OFF,
    CKMS_MUL_IDLE,
    CKMS_MUL_ACQ,
    CKMS_MUL_LOCK
  } ckms_mul_state_t;

endpackage

// ---- core/ckms_div.sv ----
`timescale 1ns/1ps
module ckms_div
  import ckms_pkg::*;
#(
  parameter int DIV = 2
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic src,
  output logic      div_q
);

  logic       prev_q;
  logic [7:0] cnt_q;

  // Toggles every DIV source edges, giving an even duty for any divisor.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      cnt_q  <= 8'h00;
      div_q  <= 1'b0;
    end else begin
      prev_q <= src;
      if (src != prev_q) begin
        if (cnt_q == 8'(DIV - 1)) begin
          cnt_q <= 8'h00;
          div_q <= ~div_q;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

endmodule // ckms_div

// ---- core/ckms_top.sv ----
`timescale 1ns/1ps
// How it works
// - Multiplier output runs at four times input.
// - Control bit 7 enables the multiplier.
// - Bit 6 zero at enable; later one initialises.
// - Bit 5 read-only, shows multiplier locked.
// - Control bits 4 to 2 read zero.
// - Source field picks internal, external, external/2.
// - Internal oscillator usable at once, no wait.
// - Hardware sets crystal valid once external settles.
// - System clock switchable among enabled, settled sources; the code switches to any selected source without checking either.
// - External clock stays available to peripherals.
// - Select bits 6 to 4 choose USB clock.
// - Select bits 2 to 0 choose system clock.
// - Select bits 7 and 3 read zero.
module ckms_top
  import ckms_pkg::*;
#(
  parameter int AW          = 12,
  parameter int XTAL_EDGES  = CKMS_XTAL_EDGES,
  parameter int PERIOD_W    = 16
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          int_osc_clk,
  input  wire logic          ext_osc_clk,
  input  wire logic          lfo_clk,
  input  wire logic          ext_osc_on,
  output logic               sys_clk_q,
  output logic               usb_clk_q,
  output logic               periph_ext_clk_q,
  output logic               multiplier_clk_q
);

  // ----------------------------------------------------------------------
  // Source synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] src_s1_q;
  logic [2:0] src_s2_q;
  logic       int_s;
  logic       ext_s;
  logic       lfo_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_s1_q <= 3'h0;
      src_s2_q <= 3'h0;
    end else begin
      src_s1_q <= {lfo_clk, ext_osc_clk, int_osc_clk};
      src_s2_q <= src_s1_q;
    end
  end

  assign int_s = src_s2_q[0];
  assign ext_s = src_s2_q[1];
  assign lfo_s = src_s2_q[2];

  // ----------------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------------
  logic int_d2;
  logic ext_d2;
  logic ext_d3;
  logic ext_d4;
  logic mul_d2;

  ckms_div #(.DIV(2)) u_int_d2 (.aclk(aclk), .aresetn(aresetn),
                               .src(int_s), .div_q(int_d2));
  ckms_div #(.DIV(2)) u_ext_d2 (.aclk(aclk), .aresetn(aresetn),
                               .src(ext_s), .div_q(ext_d2));
  ckms_div #(.DIV(3)) u_ext_d3 (.aclk(aclk), .aresetn(aresetn),
                               .src(ext_s), .div_q(ext_d3));
  ckms_div #(.DIV(4)) u_ext_d4 (.aclk(aclk), .aresetn(aresetn),
                               .src(ext_s), .div_q(ext_d4));
  ckms_div #(.DIV(2)) u_mul_d2 (.aclk(aclk), .aresetn(aresetn),
                               .src(multiplier_clk_q), .div_q(mul_d2));

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [2:0]      usb_clock_source_q;
  logic [2:0]      system_clock_source_q;
  logic            multiplier_enable_q;
  logic            multiplier_initialise_q;
  logic [1:0]      multiplier_source_q;
  logic            multiplier_locked;
  logic            crystal_valid_flag_q;
  logic            init_start;
  logic            aw_held_q;
  logic            w_held_q;
  logic [AW-1:0]   awaddr_q;
  logic [7:0]      wdata_q;
  logic            wstrb0_q;
  logic            do_write;
  logic [9:0]      widx;
  logic [9:0]      ridx;
  ckms_mul_state_t mul_state_q;

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign widx     = awaddr_q[11:2];
  assign ridx     = s_axi_araddr[11:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 8'h00;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CKMS_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (widx == CKMS_IDX_CLOCK_SOURCE_SELECT ||
                         widx == CKMS_IDX_MULTIPLIER_CONTROL ||
                         widx == CKMS_IDX_OSC_STATUS) ?
                        CKMS_RESP_OKAY : CKMS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Clock select register; unused bits are never stored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_clock_source_q    <= CKMS_CLOCK_SOURCE_SELECT_RESET[CKMS_USB_SEL_LSB +: 3];
      system_clock_source_q <= CKMS_CLOCK_SOURCE_SELECT_RESET[CKMS_SYS_SEL_LSB +: 3];
    end else if (do_write && wstrb0_q &&
                 widx == CKMS_IDX_CLOCK_SOURCE_SELECT) begin
      usb_clock_source_q    <= wdata_q[CKMS_USB_SEL_LSB +: 3];
      system_clock_source_q <= wdata_q[CKMS_SYS_SEL_LSB +: 3];
    end
  end

  // Initialisation starts only when the multiplier was already enabled.
  assign init_start = do_write && wstrb0_q &&
                      widx == CKMS_IDX_MULTIPLIER_CONTROL &&
                      wdata_q[CKMS_MUL_INIT_BIT] &&
                      wdata_q[CKMS_MUL_EN_BIT] &&
                      multiplier_enable_q;

  // Multiplier control; bits 4 to 2 are not stored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      multiplier_enable_q     <= CKMS_MULCTL_RESET[CKMS_MUL_EN_BIT];
      multiplier_initialise_q <= CKMS_MULCTL_RESET[CKMS_MUL_INIT_BIT];
      multiplier_source_q     <= CKMS_MULCTL_RESET[CKMS_MUL_SRC_LSB +: 2];
    end else if (do_write && wstrb0_q &&
                 widx == CKMS_IDX_MULTIPLIER_CONTROL) begin
      multiplier_enable_q     <= wdata_q[CKMS_MUL_EN_BIT];
      multiplier_initialise_q <= wdata_q[CKMS_MUL_INIT_BIT];
      multiplier_source_q     <= wdata_q[CKMS_MUL_SRC_LSB +: 2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= CKMS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= CKMS_RESP_OKAY;
        s_axi_rdata   <= 32'h0000_0000;
        case (ridx)
          CKMS_IDX_CLOCK_SOURCE_SELECT: begin
            s_axi_rdata[CKMS_USB_SEL_LSB +: 3] <= usb_clock_source_q;
            s_axi_rdata[CKMS_SYS_SEL_LSB +: 3] <= system_clock_source_q;
          end
          CKMS_IDX_MULTIPLIER_CONTROL: begin
            s_axi_rdata[CKMS_MUL_EN_BIT]   <= multiplier_enable_q;
            s_axi_rdata[CKMS_MUL_INIT_BIT] <= multiplier_initialise_q;
            s_axi_rdata[CKMS_MUL_LOCK_BIT] <= multiplier_locked;
            s_axi_rdata[CKMS_MUL_SRC_LSB +: 2] <= multiplier_source_q;
          end
          CKMS_IDX_OSC_STATUS: begin
            s_axi_rdata[CKMS_XTAL_VLD_BIT] <= crystal_valid_flag_q;
          end
          default: begin
            s_axi_rresp <= CKMS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Crystal settle detector
  // ----------------------------------------------------------------------
  logic        ext_prev_q;
  logic [15:0] xtal_cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_q           <= 1'b0;
      xtal_cnt_q           <= 16'h0000;
      crystal_valid_flag_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_s;
      if (!ext_osc_on) begin
        xtal_cnt_q           <= 16'h0000;
        crystal_valid_flag_q <= 1'b0;
      end else if (ext_s && !ext_prev_q && !crystal_valid_flag_q) begin
        if (xtal_cnt_q == 16'(XTAL_EDGES - 1)) begin
          crystal_valid_flag_q <= 1'b1;
        end
        xtal_cnt_q <= xtal_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // 4x multiplier
  // ----------------------------------------------------------------------
  logic                mul_in;
  logic                mul_in_prev_q;
  logic                mul_rise;
  logic [PERIOD_W-1:0] per_cnt_q;
  logic [PERIOD_W-1:0] period_q;
  logic [PERIOD_W-1:0] half_q;
  logic [PERIOD_W-1:0] gen_cnt_q;

  always_comb begin
    case (multiplier_source_q)
      CKMS_MSRC_INT:  mul_in = int_s;
      CKMS_MSRC_EXT:  mul_in = ext_s;
      CKMS_MSRC_EXT2: mul_in = ext_d2;
      default:        mul_in = 1'b0;
    endcase
  end

  assign mul_rise          = mul_in && !mul_in_prev_q;
  assign multiplier_locked = (mul_state_q == CKMS_MUL_LOCK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mul_in_prev_q <= 1'b0;
      per_cnt_q     <= '0;
      period_q      <= '0;
    end else begin
      mul_in_prev_q <= mul_in;
      if (mul_rise) begin
        per_cnt_q <= PERIOD_W'(1);
        period_q  <= per_cnt_q;
      end else if (per_cnt_q != '1) begin
        per_cnt_q <= per_cnt_q + PERIOD_W'(1);
      end
    end
  end

  // Lock needs two matching input periods after initialisation.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mul_state_q <= CKMS_MUL_OFF;
    end else if (!multiplier_enable_q) begin
      mul_state_q <= CKMS_MUL_OFF;
    end else if (init_start) begin
      mul_state_q <= CKMS_MUL_ACQ;
    end else begin
      case (mul_state_q)
        CKMS_MUL_OFF:  mul_state_q <= CKMS_MUL_IDLE;
        CKMS_MUL_IDLE: mul_state_q <= CKMS_MUL_IDLE;
        CKMS_MUL_ACQ: begin
          if (mul_rise && per_cnt_q >= PERIOD_W'(CKMS_MIN_PERIOD) &&
              per_cnt_q == period_q) begin
            mul_state_q <= CKMS_MUL_LOCK;
          end
        end
        CKMS_MUL_LOCK: begin
          if (per_cnt_q == '1) begin
            mul_state_q <= CKMS_MUL_ACQ;
          end
        end
        default: mul_state_q <= CKMS_MUL_OFF;
      endcase
    end
  end

  // Output half period is one eighth of the input period.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q           <= '0;
      gen_cnt_q        <= '0;
      multiplier_clk_q <= 1'b0;
    end else if (mul_state_q != CKMS_MUL_LOCK) begin
      half_q           <= period_q / PERIOD_W'(2 * CKMS_MUL_FACTOR);
      gen_cnt_q        <= '0;
      multiplier_clk_q <= 1'b0;
    end else if (mul_rise) begin
      half_q           <= period_q / PERIOD_W'(2 * CKMS_MUL_FACTOR);
      gen_cnt_q        <= PERIOD_W'(1);
      multiplier_clk_q <= 1'b1;
    end else if (gen_cnt_q >= half_q) begin
      gen_cnt_q        <= PERIOD_W'(1);
      multiplier_clk_q <= ~multiplier_clk_q;
    end else begin
      gen_cnt_q <= gen_cnt_q + PERIOD_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Glitch-free selection
  // ----------------------------------------------------------------------
  logic [7:0] sys_srcs;
  logic [7:0] usb_srcs;
  logic [2:0] sys_act_q;
  logic [2:0] usb_act_q;
  logic       sys_park_q;
  logic       usb_park_q;

  // Internal oscillator is used directly, with no start-up hold.
  assign sys_srcs = {3'h0, lfo_s, multiplier_clk_q, mul_d2, ext_s, int_s};
  assign usb_srcs = {2'h0, ext_d4, ext_d3, ext_d2, ext_s, int_d2,
                     multiplier_clk_q};

  // Old output parks low, then the new source is joined while low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_act_q  <= CKMS_SYS_INT;
      sys_park_q <= 1'b0;
      sys_clk_q  <= 1'b0;
    end else begin
      if (sys_park_q) begin
        sys_clk_q <= 1'b0;
        if (!sys_srcs[system_clock_source_q]) begin
          sys_act_q  <= system_clock_source_q;
          sys_park_q <= 1'b0;
        end
      end else if (sys_act_q != system_clock_source_q && !sys_clk_q) begin
        sys_park_q <= 1'b1;
        sys_clk_q  <= 1'b0;
      end else begin
        sys_clk_q <= sys_srcs[sys_act_q];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_act_q  <= CKMS_USB_MUL;
      usb_park_q <= 1'b0;
      usb_clk_q  <= 1'b0;
    end else begin
      if (usb_park_q) begin
        usb_clk_q <= 1'b0;
        if (!usb_srcs[usb_clock_source_q]) begin
          usb_act_q  <= usb_clock_source_q;
          usb_park_q <= 1'b0;
        end
      end else if (usb_act_q != usb_clock_source_q && !usb_clk_q) begin
        usb_park_q <= 1'b1;
        usb_clk_q  <= 1'b0;
      end else begin
        usb_clk_q <= usb_srcs[usb_act_q];
      end
    end
  end

  // External clock always reaches the peripherals.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_ext_clk_q <= 1'b0;
    end else begin
      periph_ext_clk_q <= ext_s;
    end
  end

endmodule // ckms_top

// ---- verif/ckms_monitor.sv ----
`timescale 1ns/1ps
module ckms_monitor
  import ckms_pkg::*;
#(
  parameter int AW = 12
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic [1:0]    s_axi_rresp,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          ext_osc_clk,
  input wire logic          sys_clk_q,
  input wire logic          usb_clk_q,
  input wire logic          periph_ext_clk_q
);
  // ------------------------------------------------------------------
  // Address of the read under way
  // ------------------------------------------------------------------
  localparam logic [AW-1:0] A_SEL = {CKMS_IDX_CLOCK_SOURCE_SELECT, 2'h0};
  localparam logic [AW-1:0] A_MUL = {CKMS_IDX_MULTIPLIER_CONTROL, 2'h0};
  localparam logic [AW-1:0] A_STA = {CKMS_IDX_OSC_STATUS, 2'h0};
  logic [AW-1:0] rd_addr_q;
  logic          mapped;
  assign mapped = (rd_addr_q == A_SEL) || (rd_addr_q == A_MUL)
                  || (rd_addr_q == A_STA);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_q <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_q <= s_axi_araddr;
    end
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence r_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  a_read_holds: assert property (r_waiting |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before taken");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer changed before taken");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_ctl_unused: assert property (
      s_axi_rvalid && rd_addr_q == A_MUL |-> s_axi_rdata[4:2] == 3'h0)
    else $error("control unused bits not zero");
  a_sel_unused: assert property (
      s_axi_rvalid && rd_addr_q == A_SEL |->
      !s_axi_rdata[7] && !s_axi_rdata[3])
    else $error("select unused bits not zero");
  a_unmapped_err: assert property (s_axi_rvalid && !mapped |->
      s_axi_rresp == CKMS_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_ext_periph: assert property (
      ext_osc_clk [*6] |-> periph_ext_clk_q)
    else $error("external clock missing at peripherals");
  a_sys_no_glitch: assert property (
      !$stable(sys_clk_q) |=> $stable(sys_clk_q))
    else $error("system clock pulse too short");
  a_usb_no_glitch: assert property (
      !$stable(usb_clk_q) |=> $stable(usb_clk_q))
    else $error("usb clock pulse too short");
endmodule // ckms_monitor

bind ckms_top ckms_monitor #(.AW(AW)) mon_u (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .ext_osc_clk, .sys_clk_q, .usb_clk_q,
  .periph_ext_clk_q
);

// ---- verif/clock_multiplier_and_clock_select_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED at %0t: got %0h exp %0h", $time, g, e); end end
module clock_multiplier_and_clock_select_tb_top
  import ckms_pkg::*;
  ;
  localparam logic [11:0] A_SEL = {CKMS_IDX_CLOCK_SOURCE_SELECT, 2'h0};
  localparam logic [11:0] A_MUL = {CKMS_IDX_MULTIPLIER_CONTROL, 2'h0};
  localparam logic [11:0] A_STA = {CKMS_IDX_OSC_STATUS, 2'h0};
  logic        aclk          = 1'h0;
  logic        aresetn       = 1'h0;
  logic [11:0] s_axi_awaddr  = '0;
  logic        s_axi_awvalid = 1'h0;
  logic [31:0] s_axi_wdata   = '0;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'h0;
  logic        s_axi_bready  = 1'h0;
  logic [11:0] s_axi_araddr  = '0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready  = 1'h0;
  logic        int_osc_clk   = 1'h0;
  logic        ext_osc_clk   = 1'h0;
  logic        lfo_clk       = 1'h0;
  logic        ext_osc_on    = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, sys_clk_q, usb_clk_q, periph_ext_clk_q;
  logic        multiplier_clk_q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic [15:0] cyc           = '0;
  logic [5:0]  ecnt          = '0;
  int          num_errors    = 0;
  int          n_tests       = 0;
  int          cs, cu, cm, cp;

  // ------------------------------------------------------------------
  // Clock and oscillator sources (periods 32, 40 and 64 cycles)
  // ------------------------------------------------------------------
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc         <= cyc + 16'h1;
    ecnt        <= (ecnt == 6'h27) ? 6'h0 : ecnt + 6'h1;
    int_osc_clk <= cyc[4];
    lfo_clk     <= cyc[5];
    ext_osc_clk <= (ecnt < 6'h14);
  end

  ckms_top #(.XTAL_EDGES(4)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .int_osc_clk, .ext_osc_clk, .lfo_clk, .ext_osc_on, .sys_clk_q,
    .usb_clk_q, .periph_ext_clk_q, .multiplier_clk_q
  );

  // ------------------------------------------------------------------
  // Bus and measurement helpers
  // ------------------------------------------------------------------
  task automatic wrap_up;
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic fail_to;
    num_errors++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    wrap_up();
  endtask

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > 99) fail_to();
    end while (s !== 1'h1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bit pa;
    bit pw;
    int n;
    pa = 1;
    pw = 1;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin
        s_axi_awvalid <= 1'h0;
        pa = 0;
      end
      if (pw && s_axi_wready) begin
        s_axi_wvalid <= 1'h0;
        pw = 0;
      end
      n++;
      if (n > 99) fail_to();
    end
    wait_hi(s_axi_bvalid);
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    wait_hi(s_axi_arready);
    s_axi_arvalid <= 1'h0;
    wait_hi(s_axi_rvalid);
    s_axi_rready  <= 1'h1;
    @(posedge aclk);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready  <= 1'h0;
  endtask

  task automatic meas(input int w);
    logic ps, pu, pm, pp;
    cs = 0;
    cu = 0;
    cm = 0;
    cp = 0;
    {ps, pu, pm, pp} = {sys_clk_q, usb_clk_q, multiplier_clk_q,
                        periph_ext_clk_q};
    repeat (w) begin
      @(posedge aclk);
      cs += int'(sys_clk_q && !ps);
      cu += int'(usb_clk_q && !pu);
      cm += int'(multiplier_clk_q && !pm);
      cp += int'(periph_ext_clk_q && !pp);
      {ps, pu, pm, pp} = {sys_clk_q, usb_clk_q, multiplier_clk_q,
                          periph_ext_clk_q};
    end
  endtask

  function automatic logic near(input int g, input int e);
    return (g >= e - 1) && (g <= e + 1);
  endfunction

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs;
    rd(A_SEL);
    `CHK(rdat, {24'h0, CKMS_CLOCK_SOURCE_SELECT_RESET})
    rd(A_MUL);
    `CHK(rdat, {24'h0, CKMS_MULCTL_RESET})
    wr(A_SEL, 8'hFF);
    rd(A_SEL);
    `CHK(rdat, 32'h77)
    wr(A_SEL, 8'h10);
    wr(A_MUL, 8'h7F);
    rd(A_MUL);
    `CHK(rdat, 32'h43)
    wr(A_MUL, 8'h00);
    wr(12'h000, 8'h55);
    `CHK(resp, CKMS_RESP_SLVERR)
    rd(12'h000);
    `CHK(resp, CKMS_RESP_SLVERR)
    `CHK(rdat, 32'h0)
  endtask

  task automatic t_xtal;
    ext_osc_on <= 1'h1;
    rd(A_STA);
    `CHK(rdat, 32'h0)
    repeat (40000) @(posedge aclk);
    rd(A_STA);
    `CHK(rdat, 32'h1)
    ext_osc_on <= 1'h0;
    repeat (4) @(posedge aclk);
    rd(A_STA);
    `CHK(rdat, 32'h0)
    ext_osc_on <= 1'h1;
    repeat (400) @(posedge aclk);
  endtask

  task automatic t_mul(input logic [1:0] s, input int e, input bit keep);
    logic lk;
    wr(A_MUL, 8'h00);
    wr(A_MUL, {6'h00, s});
    wr(A_MUL, {6'h20, s});
    repeat (240) @(posedge aclk);
    rd(A_MUL);
    `CHK(rdat[5], 1'h0)
    wr(A_MUL, {6'h30, s});
    lk = 1'h0;
    for (int n = 0; n < 100 && !lk; n++) begin
      rd(A_MUL);
      lk = rdat[5];
      repeat (8) @(posedge aclk);
    end
    `CHK(lk, s != 2'h3)
    repeat (64) @(posedge aclk);
    meas(480);
    `CHK(near(cm, e), 1'h1)
    if (!keep) begin
      wr(A_MUL, 8'h00);
      rd(A_MUL);
      `CHK(rdat[5], 1'h0)
      meas(64);
      `CHK(cm, 0)
      wr(A_MUL, {6'h20, s});
      repeat (300) @(posedge aclk);
      rd(A_MUL);
      `CHK(rdat[5], 1'h0)
      wr(A_MUL, 8'h00);
    end
  endtask

  task automatic t_sel;
    int es[8] = '{15, 12, 30, 60, 7, 0, 0, 0};
    int eu[8] = '{60, 7, 12, 6, 4, 3, 0, 0};
    for (int i = 0; i < 8; i++) begin
      wr(A_SEL, {1'h0, 3'(i), 1'h0, 3'(i)});
      repeat (300) @(posedge aclk);
      meas(480);
      `CHK(near(cs, es[i]), 1'h1)
      `CHK(near(cu, eu[i]), 1'h1)
      `CHK(near(cp, 12), 1'h1)
    end
    wr(A_SEL, 8'h10);
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_xtal();
    t_mul(2'h3, 0, 0);
    t_mul(2'h2, 24, 0);
    t_mul(2'h1, 48, 0);
    t_mul(2'h0, 60, 1);
    t_sel();
    wrap_up();
  end
endmodule // clock_multiplier_and_clock_select_tb_top
